/* File: logic/lbd_cfg.svh */
`ifndef LBD_CFG_SVH
`define LBD_CFG_SVH
`define LBD_IDX_CH5      8'h29
`define LBD_IDX_CH6      8'h2A
`define LBD_IDX_CH7      8'h2B
`define LBD_IDX_CH8      8'h2C
`define LBD_ADDR_W       8
`define LBD_DUTY_W       12
`define LBD_DUTY_MSB     11
`define LBD_FADE_BIT     12
`define LBD_REG_W        13
`define LBD_REG_RESET    13'h0000
`define LBD_DUTY_OFF     12'h000
`define LBD_DUTY_FULL    12'hFFF
`define LBD_PERIOD_LAST  12'hFFE
`define LBD_RESP_OKAY    2'h0
`define LBD_RESP_SLVERR  2'h2
`endif

/* File: logic/lbd_dim_channel.sv */
`timescale 1ns/1ns
`include "lbd_cfg.svh"
module lbd_dim_channel
	import lbd_pkg::*;
(
	input  wire logic      aclk,
	input  wire logic      aresetn,
	input  wire logic [11:0] count,
	input  wire lbd_reg_t  cfg,
	output logic           dim_out
);
	typedef struct packed {
		logic out;
	} lbd_ch_s;
	lbd_ch_s st, next_st;

	always_comb begin
		next_st = st;
		if (cfg[`LBD_FADE_BIT])
			next_st.out = (cfg[`LBD_DUTY_MSB:0] != `LBD_DUTY_OFF);
		else if (cfg[`LBD_DUTY_MSB:0] == `LBD_DUTY_FULL)
			next_st.out = 1'b1;
		else
			next_st.out = (count < cfg[`LBD_DUTY_MSB:0]);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;
	end
	assign dim_out = st.out;
endmodule : lbd_dim_channel

/* File: logic/lbd_dim_regs.sv */
`timescale 1ns/1ns
`include "lbd_cfg.svh"
module lbd_dim_regs
	import lbd_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [9:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [9:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [3:0]       dim_out
);
	typedef struct packed {
		logic       aw_ready;
		logic [9:0] aw_addr;
		logic       w_ready;
		logic       ar_ready;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic       bvalid;
		logic [1:0] bresp;
		logic       rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [11:0] count;
		lbd_reg_t   cfg0;
		lbd_reg_t   cfg1;
		lbd_reg_t   cfg2;
		lbd_reg_t   cfg3;
	} lbd_st_s;
	lbd_st_s st, next_st;

	// Byte address is four times the register index; returns channel 0..3 or 4 for unmapped.
	function automatic logic [2:0] lbd_decode(input logic [9:0] a);
		if (a[1:0] != 2'h0)
			return 3'h4;
		case (a[9:2])
			`LBD_IDX_CH5: return 3'h0;
			`LBD_IDX_CH6: return 3'h1;
			`LBD_IDX_CH7: return 3'h2;
			`LBD_IDX_CH8: return 3'h3;
			default:      return 3'h4;
		endcase
	endfunction : lbd_decode

	function automatic lbd_reg_t lbd_merge(input lbd_reg_t old, input logic [31:0] d, input logic [3:0] s);
		lbd_reg_t r;
		r = old;
		if (s[0])
			r[7:0] = d[7:0];
		if (s[1])
			r[12:8] = d[12:8];
		return r;
	endfunction : lbd_merge

	logic [2:0] wsel;
	logic [2:0] rsel;
	logic       do_write;
	logic [3:0] ch_out;

	always_comb begin
		next_st = st;
		wsel = lbd_decode(st.aw_addr);
		rsel = lbd_decode(s_axi_araddr);
		do_write = !st.aw_ready && !st.w_ready && !st.bvalid;
		// Counter wraps after 4095 states so duty 0xFFF would otherwise never be fully on.
		next_st.count = (st.count == `LBD_PERIOD_LAST) ? 12'h000 : st.count + 12'h001;
		if (s_axi_awvalid && st.aw_ready) begin
			next_st.aw_ready = 1'b0;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st.w_ready) begin
			next_st.w_ready = 1'b0;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			next_st.aw_ready = 1'b1;
			next_st.w_ready = 1'b1;
			next_st.bvalid = 1'b1;
			next_st.bresp = (wsel == 3'h4) ? `LBD_RESP_SLVERR : `LBD_RESP_OKAY;
			case (wsel)
				3'h0: next_st.cfg0 = lbd_merge(st.cfg0, st.w_data, st.w_strb);
				3'h1: next_st.cfg1 = lbd_merge(st.cfg1, st.w_data, st.w_strb);
				3'h2: next_st.cfg2 = lbd_merge(st.cfg2, st.w_data, st.w_strb);
				3'h3: next_st.cfg3 = lbd_merge(st.cfg3, st.w_data, st.w_strb);
				default: next_st.bresp = `LBD_RESP_SLVERR;
			endcase
		end
		if (st.bvalid && s_axi_bready)
			next_st.bvalid = 1'b0;
		if (s_axi_arvalid && st.ar_ready) begin
			next_st.ar_ready = 1'b0;
			next_st.rvalid = 1'b1;
			next_st.rresp = (rsel == 3'h4) ? `LBD_RESP_SLVERR : `LBD_RESP_OKAY;
			case (rsel)
				3'h0: next_st.rdata = {19'h00000, st.cfg0};
				3'h1: next_st.rdata = {19'h00000, st.cfg1};
				3'h2: next_st.rdata = {19'h00000, st.cfg2};
				3'h3: next_st.rdata = {19'h00000, st.cfg3};
				default: next_st.rdata = 32'h00000000;
			endcase
		end
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
			next_st.ar_ready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			// Ready flags are flops of their own so that every bus output leaves a register.
			st.aw_ready <= 1'b1;
			st.w_ready <= 1'b1;
			st.ar_ready <= 1'b1;
			st.cfg0 <= `LBD_REG_RESET;
			st.cfg1 <= `LBD_REG_RESET;
			st.cfg2 <= `LBD_REG_RESET;
			st.cfg3 <= `LBD_REG_RESET;
		end else begin
			st <= next_st;
		end
	end

	lbd_dim_channel u_ch0 (.aclk(aclk), .aresetn(aresetn), .count(st.count), .cfg(st.cfg0), .dim_out(ch_out[0]));
	lbd_dim_channel u_ch1 (.aclk(aclk), .aresetn(aresetn), .count(st.count), .cfg(st.cfg1), .dim_out(ch_out[1]));
	lbd_dim_channel u_ch2 (.aclk(aclk), .aresetn(aresetn), .count(st.count), .cfg(st.cfg2), .dim_out(ch_out[2]));
	lbd_dim_channel u_ch3 (.aclk(aclk), .aresetn(aresetn), .count(st.count), .cfg(st.cfg3), .dim_out(ch_out[3]));

	assign s_axi_awready = st.aw_ready;
	assign s_axi_wready  = st.w_ready;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_arready = st.ar_ready;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rresp   = st.rresp;
	assign s_axi_rdata   = st.rdata;
	assign dim_out       = ch_out;

	property p_duty_off;
		@(posedge aclk) disable iff (!aresetn)
		(st.cfg0[11:0] == 12'h000 && $stable(st.cfg0)) |=> !dim_out[0];
	endproperty
	a_duty_off: assert property (p_duty_off) else $error("zero duty drove output");

	property p_duty_one;
		@(posedge aclk) disable iff (!aresetn)
		(st.cfg0 == 13'h0001 && st.count == 12'h000 && $stable(st.cfg0)) |=> dim_out[0];
	endproperty
	a_duty_one: assert property (p_duty_one) else $error("duty one not high at count zero");

	property p_full;
		@(posedge aclk) disable iff (!aresetn)
		(st.cfg1 == 13'h0FFF)[*2] |-> dim_out[1];
	endproperty
	a_full: assert property (p_full) else $error("full duty dropped output");

	property p_disable;
		@(posedge aclk) disable iff (!aresetn)
		(st.cfg3[12] && st.cfg3[11:0] != 12'h000)[*2] |-> dim_out[3];
	endproperty
	a_disable: assert property (p_disable) else $error("disabled dimming not static on");

	property p_cmp;
		@(posedge aclk) disable iff (!aresetn)
		(!st.cfg0[12] && st.cfg0[11:0] != 12'hFFF && $stable(st.cfg0))
			|=> (dim_out[0] == ($past(st.count) < $past(st.cfg0[11:0])));
	endproperty
	a_cmp: assert property (p_cmp) else $error("output does not follow counter compare");

	property p_wrap;
		@(posedge aclk) disable iff (!aresetn)
		(st.count == 12'hFFE) |=> (st.count == 12'h000);
	endproperty
	a_wrap: assert property (p_wrap) else $error("period counter did not wrap at 4095");

	property p_rd5;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == 10'h0A4) |=> (s_axi_rvalid && s_axi_rdata == {19'h0, $past(st.cfg0)});
	endproperty
	a_rd5: assert property (p_rd5) else $error("channel five readback wrong");

	property p_wr6;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && st.aw_addr == 10'h0A8 && st.w_strb == 4'hF) |=> (st.cfg1 == $past(st.w_data[12:0]));
	endproperty
	a_wr6: assert property (p_wr6) else $error("channel six write lost");

	property p_wr7;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && st.aw_addr == 10'h0AC) |=> (s_axi_bvalid && s_axi_bresp == 2'h0);
	endproperty
	a_wr7: assert property (p_wr7) else $error("channel seven write not acknowledged");

	property p_rd8;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == 10'h0B0) |=> (s_axi_rresp == 2'h0 && s_axi_rdata[31:13] == 19'h0);
	endproperty
	a_rd8: assert property (p_rd8) else $error("channel eight read failed");

	sequence s_ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence

	sequence s_write_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
	endsequence

	sequence s_write_answer;
		##2 s_axi_bvalid;
	endsequence

	property p_wr_answer;
		@(posedge aclk) disable iff (!aresetn)
		s_write_taken |-> s_write_answer;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write response late");

	property p_wr_block;
		@(posedge aclk) disable iff (!aresetn)
		s_write_taken |=> (!s_axi_awready && !s_axi_wready);
	endproperty
	a_wr_block: assert property (p_wr_block) else $error("write channels not blocked while held");

	property p_rd_answer;
		@(posedge aclk) disable iff (!aresetn)
		s_ar_take |=> (s_axi_rvalid && !s_axi_arready);
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read response late");

	property p_resp_clear;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && s_axi_bready) |=> (!s_axi_bvalid && s_axi_awready && s_axi_wready);
	endproperty
	a_resp_clear: assert property (p_resp_clear) else $error("write response not retired");

	property p_rresp_clear;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_rvalid && s_axi_rready) |=> (!s_axi_rvalid && s_axi_arready);
	endproperty
	a_rresp_clear: assert property (p_rresp_clear) else $error("read response not retired");

	property p_rd_unmapped;
		@(posedge aclk) disable iff (!aresetn)
		s_ar_take ##0 (rsel == 3'h4) |=> (s_axi_rresp == `LBD_RESP_SLVERR && s_axi_rdata == 32'h00000000);
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not refused");

	property p_wr_unmapped;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && wsel == 3'h4) |=> (s_axi_bresp == `LBD_RESP_SLVERR && $stable(st.cfg0) && $stable(st.cfg1)
			&& $stable(st.cfg2) && $stable(st.cfg3));
	endproperty
	a_wr_unmapped: assert property (p_wr_unmapped) else $error("unmapped write not refused");

	property p_strobe;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && wsel == 3'h0 && st.w_strb[1:0] == 2'h2)
			|=> (st.cfg0[7:0] == $past(st.cfg0[7:0]) && st.cfg0[12:8] == $past(st.w_data[12:8]));
	endproperty
	a_strobe: assert property (p_strobe) else $error("byte strobes not honoured");

	property p_reset_state;
		@(posedge aclk)
		!aresetn |=> (st.cfg0 == `LBD_REG_RESET && st.cfg1 == `LBD_REG_RESET && st.cfg2 == `LBD_REG_RESET
			&& st.cfg3 == `LBD_REG_RESET && st.count == 12'h000 && dim_out == 4'h0
			&& s_axi_awready && s_axi_wready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid);
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

	property p_count_step;
		@(posedge aclk) disable iff (!aresetn)
		(st.count != `LBD_PERIOD_LAST) |=> (st.count == $past(st.count) + 12'h001);
	endproperty
	a_count_step: assert property (p_count_step) else $error("period counter skipped");

	property p_count_range;
		@(posedge aclk) disable iff (!aresetn)
		st.count <= `LBD_PERIOD_LAST;
	endproperty
	a_count_range: assert property (p_count_range) else $error("period counter out of range");

	property p_cmp8;
		@(posedge aclk) disable iff (!aresetn)
		(!st.cfg3[12] && st.cfg3[11:0] != 12'hFFF && $stable(st.cfg3))
			|=> (dim_out[3] == ($past(st.count) < $past(st.cfg3[11:0])));
	endproperty
	a_cmp8: assert property (p_cmp8) else $error("channel eight does not follow compare");

	property p_dis_off;
		@(posedge aclk) disable iff (!aresetn)
		(st.cfg2[12] && st.cfg2[11:0] == 12'h000)[*2] |-> !dim_out[2];
	endproperty
	a_dis_off: assert property (p_dis_off) else $error("disabled zero duty drove output");
endmodule : lbd_dim_regs

/* File: logic/lbd_pkg.sv */
package lbd_pkg;
	typedef logic [12:0] lbd_reg_t;
	typedef logic [11:0] lbd_duty_t;
	typedef enum logic [1:0] {LBD_IDLE, LBD_BRESP, LBD_RRESP} lbd_bus_e;
endpackage : lbd_pkg

/* File: tb/test_led_bypass_dimming_regs_5_to_8.sv */
`timescale 1ns/1ns
`include "lbd_cfg.svh"
module test_led_bypass_dimming_regs_5_to_8
	import lbd_pkg::*;
;
	typedef struct {logic [9:0] a; logic [31:0] d; logic [31:0] h;} lbd_row_s;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [9:0]  s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h0, dim_out;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] highs [4];
	int          errors = 0, total_checks = 0, cycles = 0;
	// Bits above 12 of the channel six row are written to prove they are dropped.
	lbd_row_s    rows [4] = '{'{{`LBD_IDX_CH5, 2'b00}, 32'h0000_0001, 32'h1},
		'{{`LBD_IDX_CH6, 2'b00}, 32'hFFFF_EFFF, 32'hFFF}, '{{`LBD_IDX_CH7, 2'b00}, 32'h0, 32'h0},
		'{{`LBD_IDX_CH8, 2'b00}, 32'h0000_1800, 32'hFFF}};

	lbd_dim_regs DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .dim_out);

	always #5 aclk = ~aclk;

	task automatic print_verdict;
		$display("errors %0d total_checks %0d", errors, total_checks);
		if (errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict

	// The ceiling covers three full dimming periods plus bus traffic with margin.
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			print_verdict();
		end
	end

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk_val

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t response got %h exp %h", $time, got, exp);
		end
	endtask : chk_resp

	task automatic axi_write(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		logic done;
		done = 1'b0;
		// One idle edge keeps the release of the last call apart from the raise of this one.
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				chk_resp(s_axi_bresp, er);
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : axi_write

	task automatic axi_read(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				chk_resp(s_axi_rresp, er);
				chk_val(s_axi_rdata, ed, "read data");
				s_axi_rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : axi_read

	// A window of one whole period counts every phase once, whatever the start.
	task automatic count_highs;
		highs = '{default: 32'h0};
		repeat (4) @(posedge aclk);
		repeat (4095) begin
			@(posedge aclk);
			for (int i = 0; i < 4; i++) highs[i] += (dim_out[i] === 1'b1) ? 32'h1 : 32'h0;
		end
	endtask : count_highs

	initial begin
		repeat (6) @(posedge aclk);
		chk_val({23'h0, s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid, dim_out}, 32'h1C0, "reset");
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (rows[i]) axi_read(rows[i].a, 32'h0, `LBD_RESP_OKAY);
		foreach (rows[i]) begin
			axi_write(rows[i].a, rows[i].d, 4'hF, `LBD_RESP_OKAY);
			axi_read(rows[i].a, {19'h0, rows[i].d[12:0]}, `LBD_RESP_OKAY);
		end
		count_highs();
		foreach (rows[i]) chk_val(highs[i], rows[i].h, "high cycles");
		axi_write(rows[3].a, 32'h0000_0800, 4'hF, `LBD_RESP_OKAY);
		axi_write(rows[2].a, 32'h0000_1000, 4'hF, `LBD_RESP_OKAY);
		count_highs();
		chk_val(highs[3], 32'd2048, "half duty");
		chk_val(highs[2], 32'h0, "disabled zero duty");
		axi_write(rows[0].a, 32'h0000_1AB5, 4'h2, `LBD_RESP_OKAY);
		axi_read(rows[0].a, 32'h0000_1A01, `LBD_RESP_OKAY);
		axi_write(10'h0B4, 32'h1FFF, 4'hF, `LBD_RESP_SLVERR);
		axi_read(10'h0B4, 32'h0, `LBD_RESP_SLVERR);
		axi_write(10'h0A6, 32'h0FFF, 4'hF, `LBD_RESP_SLVERR);
		axi_read(rows[0].a, 32'h0000_1A01, `LBD_RESP_OKAY);
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		chk_val({23'h0, s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid, dim_out}, 32'h1C0, "reset");
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_read(rows[1].a, 32'h0, `LBD_RESP_OKAY);
		count_highs();
		foreach (highs[i]) chk_val(highs[i], 32'h0, "off after reset");
		print_verdict();
	end
endmodule : test_led_bypass_dimming_regs_5_to_8
